// ===== hdl/ptdl_pkg.sv
/*
 * Package for the PCI target decode and lock block: command codes, CPU
 * transfer type codes, address fields, state encoding and pin carriers.
 * Assumes a single system clock domain; PCI pins are sampled into it.
 */
package ptdl_pkg;
   // ==================================================================
   // PCI bus commands
   // ==================================================================
   localparam logic [3:0] CMD_MEM_READ = 4'h6;      // Memory read
   localparam logic [3:0] CMD_MEM_WRITE = 4'h7;     // Memory write
   localparam logic [3:0] CMD_MEM_READ_MULT = 4'hC; // Memory read multiple
   localparam logic [3:0] CMD_MEM_READ_LINE = 4'hE; // Memory read line
   localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hF; // Write and invalidate
   // ==================================================================
   // CPU transfer type codes
   // ==================================================================
   localparam logic [3:0] TT_READ_ATOMIC = 4'hD;     // Reservation read
   localparam logic [3:0] TT_RWITM_ATOMIC = 4'hF;    // Read intent modify
   localparam logic [3:0] TT_WFLUSH_ATOMIC = 4'h9;   // Write flush atomic
   localparam logic [3:0] TT_WRITE_FLUSH = 4'h1;     // Lock-grant invalidate
   localparam logic [3:0] TT_SNOOP_READ = 4'hA;      // Plain snoop, reads
   localparam logic [3:0] TT_SNOOP_WRITE = 4'h6;     // Plain snoop, writes
   // ==================================================================
   // Address fields
   // ==================================================================
   localparam int ADDR_W = 32;         // PCI address width
   localparam int HIGH_BIT = 31;       // Selects the 2G..4G window
   localparam int BLOCK_LSB = 5;       // 32-byte lock block
   localparam int BLOCK_W = ADDR_W - BLOCK_LSB;
   localparam int MASTER_W = 3;        // Width of master identity
   // ==================================================================
   // Sequencer states
   // ==================================================================
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,     // Waiting for work
      ST_SNOOP = 3'b001,    // Access snoop on CPU bus
      ST_MEM = 3'b010,      // System memory cycle
      ST_LSNOOP = 3'b011,   // Lock grant or release snoop
      ST_WAIT = 3'b100      // Waiting for PCI frame to end
   } ptdl_state_e;
   // ==================================================================
   // Carriers
   // ==================================================================
   typedef struct packed
   {
      logic clk;                      // PCI clock level
      logic frame_n;                  // Frame, active low
      logic lock_n;                   // Lock, active low
      logic ign_hi;                   // ignore_high_address_bit_input
      logic [3:0] cmd;                // Bus command
      logic [ADDR_W-1:0] ad;          // Address
      logic [MASTER_W-1:0] master;    // Granted master identity
   } ptdl_pins_s;
   typedef struct packed
   {
      logic [3:0] tt;                 // Transfer type
      logic [ADDR_W-1:0] addr;        // Address
   } ptdl_cycle_s;
endpackage : ptdl_pkg

// ===== hdl/ptdl_top.sv
/*
 * PCI target decode, memory mapping and single-block lock for the host
 * bridge. Assumes PCI pins arrive asynchronously (sampled here, PCI clock
 * edges found by sampling), the CPU bus side and memory port run on mclk_i.
 */
`timescale 1ns/1ps
module ptdl_top
(
   input wire logic mclk_i,                                    // System clock
   input wire logic reset_n_i,                                 // Sync reset
   input wire ptdl_pkg::ptdl_pins_s pci_i,                     // PCI pins
   input wire logic [ptdl_pkg::ADDR_W-1:0] top_of_memory_i,   // Populated top
   input wire logic cpu_start_i,                               // CPU cycle start
   input wire ptdl_pkg::ptdl_cycle_s cpu_i,                    // CPU cycle
   input wire logic snoop_ack_i,                               // Snoop ended
   input wire logic snoop_retry_i,                             // Snoop hit retry
   input wire logic mem_ack_i,                                 // Memory done
   output logic address_retry_o,                               // CPU retry
   output logic cpu_pass_o,                                    // CPU cycle allowed
   output logic pci_claim_o,                                   // Claim level
   output logic pci_retry_o,                                   // Target retry
   output logic snoop_req_o,                                   // Snoop request
   output ptdl_pkg::ptdl_cycle_s snoop_o,                      // Snoop cycle
   output logic mem_req_o,                                     // Memory request
   output logic mem_write_o,                                   // Memory direction
   output logic [ptdl_pkg::ADDR_W-1:0] mem_addr_o              // Memory address
);
   // ==================================================================
   // Functions
   // ==================================================================
   // Read commands that may reach memory
   function automatic logic is_rd(input logic [3:0] c);
      is_rd = (c == ptdl_pkg::CMD_MEM_READ) || (c == ptdl_pkg::CMD_MEM_READ_MULT)
         || (c == ptdl_pkg::CMD_MEM_READ_LINE);
   endfunction : is_rd
   // Write commands that may reach memory
   function automatic logic is_wr(input logic [3:0] c);
      is_wr = (c == ptdl_pkg::CMD_MEM_WRITE) || (c == ptdl_pkg::CMD_MEM_WRITE_INV);
   endfunction : is_wr
   // Block number of an address
   function automatic logic [ptdl_pkg::BLOCK_W-1:0] blk(input logic [31:0] a);
      blk = a[ptdl_pkg::ADDR_W-1:ptdl_pkg::BLOCK_LSB];
   endfunction : blk

   // ==================================================================
   // Pin sampling
   // ==================================================================
   ptdl_pkg::ptdl_pins_s meta;     // First stage
   ptdl_pkg::ptdl_pins_s pin;      // Second stage, safe to use
   logic clk_prev;                 // Previous PCI clock level
   logic frame_prev;               // Frame at previous PCI edge
   logic pci_edge;                 // PCI rising edge seen
   logic addr_phase;               // Address phase at this edge

   // Two-stage capture of every PCI pin
   always_ff @(posedge mclk_i)
   begin
      meta <= pci_i;
      pin <= meta;
   end

   // PCI clock edge and frame history
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         clk_prev <= pin.clk; // Track the pin so release shows no false edge
         frame_prev <= 1'b1;
      end
      else
      begin
         clk_prev <= pin.clk;
         if (pci_edge)
            frame_prev <= pin.frame_n;
      end
   end

   assign pci_edge = pin.clk & ~clk_prev;
   assign addr_phase = pci_edge && !pin.frame_n && frame_prev;

   // ==================================================================
   // Address decode
   // ==================================================================
   logic cmd_rd;                              // Memory read command
   logic cmd_wr;                              // Memory write command
   logic [ptdl_pkg::ADDR_W-1:0] sys_addr;     // Mapped memory address
   logic in_window;                           // Address window accepted
   logic mapped;                              // Claimable memory access
   logic hits_lock;                           // Touches the locked block

   assign cmd_rd = is_rd(pin.cmd);
   assign cmd_wr = is_wr(pin.cmd);
   // Drop the top bit; both windows land at 0..2G
   assign sys_addr = {1'b0, pin.ad[ptdl_pkg::HIGH_BIT-1:0]};
   assign in_window = pin.ad[ptdl_pkg::HIGH_BIT] || pin.ign_hi;
   // Only memory commands, only populated space; nothing goes to ROM,
   // config space or the CPU bus
   assign mapped = (cmd_rd || cmd_wr) && in_window
      && (sys_addr < top_of_memory_i);

   // ==================================================================
   // Lock state
   // ==================================================================
   logic lock_valid;                             // Lock in effect
   logic [ptdl_pkg::BLOCK_W-1:0] lock_blk;       // Locked block
   logic [ptdl_pkg::MASTER_W-1:0] lock_owner;    // Owning master
   logic lock_cand;                              // Claimed access may lock
   logic [ptdl_pkg::BLOCK_W-1:0] cand_blk;       // Candidate block
   logic grant;                                  // Lock granted now
   logic release_now;                            // Owner drops lock now
   logic lsnoop_pend;                            // Lock snoop owed
   logic [3:0] lsnoop_tt;                        // Its transfer type
   logic [ptdl_pkg::BLOCK_W-1:0] lsnoop_blk;     // Its block
   ptdl_pkg::ptdl_state_e state;                 // Sequencer state

   assign hits_lock = lock_valid && (blk(sys_addr) == lock_blk);
   assign grant = lock_cand && pci_edge && !pin.lock_n && !lock_valid;
   assign release_now = lock_valid && pci_edge && pin.lock_n && pin.frame_n
      && !lock_cand;

   // Lock record: one block, one owner
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         lock_valid <= 1'b0;
         lock_blk <= '0;
         lock_owner <= '0;
      end
      else if (grant)
      begin
         lock_valid <= 1'b1;
         lock_blk <= cand_blk;
         lock_owner <= pin.master;
      end
      else if (release_now)
         lock_valid <= 1'b0;
   end

   // Candidate lock: claimed access, checked at the following PCI edge
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         lock_cand <= 1'b0;
         cand_blk <= '0;
      end
      else if (addr_phase && mapped && !hits_lock)
      begin
         lock_cand <= 1'b1;
         cand_blk <= blk(sys_addr);
      end
      else if (pci_edge)
         lock_cand <= 1'b0;
   end

   // Owed lock snoops: grant wants flush, release a plain snoop
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         lsnoop_pend <= 1'b0;
         lsnoop_tt <= ptdl_pkg::TT_SNOOP_READ;
         lsnoop_blk <= '0;
      end
      else if (grant)
      begin
         lsnoop_pend <= 1'b1;
         lsnoop_tt <= ptdl_pkg::TT_WRITE_FLUSH;
         lsnoop_blk <= cand_blk;
      end
      else if (release_now)
      begin
         lsnoop_pend <= 1'b1;
         lsnoop_tt <= ptdl_pkg::TT_SNOOP_READ;
         lsnoop_blk <= lock_blk;
      end
      else if (state == ptdl_pkg::ST_IDLE)
         lsnoop_pend <= 1'b0;
   end

   // ==================================================================
   // PCI access sequencer
   // ==================================================================
   logic [ptdl_pkg::ADDR_W-1:0] acc_addr;   // Held memory address
   logic acc_wr;                            // Held direction
   logic acc_go;                            // Access waiting for sequencer

   // Capture a claimed access at its address phase
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         acc_go <= 1'b0;
         acc_addr <= '0;
         acc_wr <= 1'b0;
      end
      else if (addr_phase && mapped
         && !(hits_lock && pin.master != lock_owner))
      begin
         acc_go <= 1'b1;
         acc_addr <= sys_addr;
         acc_wr <= cmd_wr;
      end
      else if (state == ptdl_pkg::ST_IDLE && !lsnoop_pend)
         acc_go <= 1'b0;
   end

   // Snoop, then memory; lock snoops take priority
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         state <= ptdl_pkg::ST_IDLE;
         snoop_req_o <= 1'b0;
         snoop_o <= '0;
         mem_req_o <= 1'b0;
         mem_write_o <= 1'b0;
         mem_addr_o <= '0;
      end
      else
      begin
         case (state)
            ptdl_pkg::ST_IDLE:
            begin
               if (lsnoop_pend)
               begin
                  snoop_req_o <= 1'b1;
                  snoop_o <= {lsnoop_tt, lsnoop_blk, 5'h00};
                  state <= ptdl_pkg::ST_LSNOOP;
               end
               else if (acc_go)
               begin
                  snoop_req_o <= 1'b1;
                  snoop_o <= {acc_wr ? ptdl_pkg::TT_SNOOP_WRITE
                     : ptdl_pkg::TT_SNOOP_READ, acc_addr};
                  state <= ptdl_pkg::ST_SNOOP;
               end
            end
            ptdl_pkg::ST_LSNOOP:
            begin
               if (snoop_ack_i)
               begin
                  snoop_req_o <= 1'b0;
                  state <= ptdl_pkg::ST_IDLE;
               end
            end
            ptdl_pkg::ST_SNOOP:
            begin
               if (snoop_ack_i)
               begin
                  snoop_req_o <= 1'b0;
                  // Snoop hit abandons the memory cycle
                  if (snoop_retry_i)
                     state <= ptdl_pkg::ST_WAIT;
                  else
                  begin
                     mem_req_o <= 1'b1;
                     mem_write_o <= acc_wr;
                     mem_addr_o <= acc_addr;
                     state <= ptdl_pkg::ST_MEM;
                  end
               end
            end
            ptdl_pkg::ST_MEM:
            begin
               if (mem_ack_i)
               begin
                  mem_req_o <= 1'b0;
                  state <= ptdl_pkg::ST_WAIT;
               end
            end
            ptdl_pkg::ST_WAIT:
            begin
               if (pci_edge && pin.frame_n)
                  state <= ptdl_pkg::ST_IDLE;
            end
            default:
               state <= ptdl_pkg::ST_IDLE;
         endcase
      end
   end

   // ==================================================================
   // PCI target answers
   // ==================================================================
   // Claim and retry hold until a PCI edge sees the frame ended, the sequencer idle and no access pending
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         pci_claim_o <= 1'b0;
         pci_retry_o <= 1'b0;
      end
      else if (addr_phase && mapped)
      begin
         pci_claim_o <= 1'b1;
         pci_retry_o <= hits_lock && (pin.master != lock_owner);
      end
      else if (state == ptdl_pkg::ST_SNOOP && snoop_ack_i && snoop_retry_i)
         pci_retry_o <= 1'b1;
      else if (pci_edge && pin.frame_n && state == ptdl_pkg::ST_IDLE && !acc_go)
      begin
         pci_claim_o <= 1'b0;
         pci_retry_o <= 1'b0;
      end
   end

   // ==================================================================
   // CPU bus checks
   // ==================================================================
   logic cpu_hit;   // CPU cycle touches locked block
   assign cpu_hit = lock_valid && (blk(cpu_i.addr) == lock_blk);

   // Any TT to a locked block retried; otherwise passed unchanged
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         address_retry_o <= 1'b0;
         cpu_pass_o <= 1'b0;
      end
      else
      begin
         address_retry_o <= cpu_start_i && cpu_hit;
         cpu_pass_o <= cpu_start_i && !cpu_hit;
      end
   end

   // ==================================================================
   // Checks
   // ==================================================================
   chk_cpu_lock_retry: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      cpu_start_i && cpu_hit |=> address_retry_o && !cpu_pass_o)
      else $error("CPU access to locked block not retried");
   chk_atomic_read_pass: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      cpu_start_i && !lock_valid && cpu_i.tt == ptdl_pkg::TT_READ_ATOMIC
      |=> cpu_pass_o && !address_retry_o)
      else $error("Unlocked read atomic not passed");
   chk_single_lock: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      lock_valid && !release_now |=> $stable(lock_blk) && $stable(lock_owner))
      else $error("Second lock granted over held lock");
   chk_grant_flush: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      grant |=> lsnoop_pend && lsnoop_tt == ptdl_pkg::TT_WRITE_FLUSH)
      else $error("Lock grant without flush snoop");
   chk_release_snoop: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      release_now |=> !lock_valid && lsnoop_pend && lsnoop_tt == ptdl_pkg::TT_SNOOP_READ)
      else $error("Lock release wrong");
   chk_low_unclaimed: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      addr_phase && !pin.ad[ptdl_pkg::HIGH_BIT] && !pin.ign_hi && !pci_claim_o
      |=> !pci_claim_o && !acc_go)
      else $error("Low address claimed without ignore bit");
   chk_nonmem_ignored: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      addr_phase && !cmd_rd && !cmd_wr && !pci_claim_o |=> !pci_claim_o)
      else $error("Non-memory command claimed");
   chk_owner_retry: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      addr_phase && mapped && hits_lock && pin.master != lock_owner
      |=> pci_retry_o && !acc_go)
      else $error("Non-owner not retried on locked block");
   chk_snoop_then_mem: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      state == ptdl_pkg::ST_SNOOP && snoop_ack_i && !snoop_retry_i
      |=> mem_req_o && mem_addr_o == $past(acc_addr))
      else $error("Memory not accessed after clean snoop");
endmodule : ptdl_top

// ===== verification/ptdl_far.sv
/*
 * Far-side model: the CPU bus agent and memory that answer the bridge.
 * Assumes requests are levels that are held until acknowledged.
 */
`timescale 1ns/1ps
module ptdl_far
(
   input wire logic mclk_i,                   // System clock
   input wire logic snoop_req_i,              // Snoop request
   input wire ptdl_pkg::ptdl_cycle_s snoop_i, // Snoop cycle
   input wire logic mem_req_i,                // Memory request
   input wire logic hit_i,                    // Answer snoops with a hit
   input wire logic [7:0] delay_i,            // Answer delay in cycles
   output logic snoop_ack_o,                  // Snoop ended
   output logic snoop_retry_o,                // Snoop hit
   output logic mem_ack_o                     // Memory done
);
   // ==================================================
   // Answer timing and records
   // ==================================================
   logic [7:0] cnt = 8'h00;      // Cycles the request has waited
   logic ret = 1'b0;             // Hit setting at the last snoop or memory answer
   int snoops = 0;               // Snoop cycles answered
   int mems = 0;                 // Memory cycles answered
   ptdl_pkg::ptdl_cycle_s last;  // Last snoop cycle seen
   initial
   begin
      snoop_ack_o = 1'b0;
      mem_ack_o = 1'b0;
   end
   // Outside the ack cycle the hit line shows a stale inverse
   assign snoop_retry_o = snoop_ack_o ? ret : ~ret;
   // Wait the set delay, then pulse one ack
   always @(posedge mclk_i)
   begin
      snoop_ack_o <= 1'b0;
      mem_ack_o <= 1'b0;
      if ((snoop_req_i | mem_req_i) & ~snoop_ack_o & ~mem_ack_o)
      begin
         cnt <= cnt + 8'h01;
         if (cnt >= delay_i)
         begin
            cnt <= 8'h00;
            snoop_ack_o <= snoop_req_i;
            mem_ack_o <= ~snoop_req_i;
            ret <= hit_i;
            if (snoop_req_i)
               last <= snoop_i;
            if (snoop_req_i)
               snoops <= snoops + 1;
            else
               mems <= mems + 1;
         end
      end
      else
         cnt <= 8'h00;
   end
endmodule : ptdl_far

// ===== verification/tb.sv
/*
 * Self-checking bench for the PCI target decode and lock block.
 * Assumes the far-side model ptdl_far and a free-running PCI clock.
 */
`timescale 1ns/1ps
module tb;
   // ==================================================
   // Signals
   // ==================================================
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   ptdl_pkg::ptdl_pins_s pci_i = {3'h3, 40'h0};  // Idle: clock low, frame and lock high
   logic cpu_start_i = 1'b0;
   ptdl_pkg::ptdl_cycle_s cpu_i = 36'h0;
   logic snoop_ack_i, snoop_retry_i, mem_ack_i;
   logic address_retry_o, cpu_pass_o, pci_claim_o, pci_retry_o;
   logic snoop_req_o, mem_req_o, mem_write_o;
   ptdl_pkg::ptdl_cycle_s snoop_o;
   logic [31:0] mem_addr_o;
   logic hit = 1'b0;                 // Far side answers with a hit
   logic [7:0] delay = 8'h02;        // Far side answer delay
   logic saw_claim = 1'b0;           // Claim seen in this transaction
   logic saw_retry = 1'b0;           // Retry seen in this transaction
   logic saw_wr = 1'b0;              // Last memory direction
   logic [31:0] saw_addr = 32'h0;    // Last memory address
   int fail_count = 0;
   int check_count = 0;
   // Clocks: system 10 ns, PCI 125 ns at an unrelated phase
   initial forever #5 mclk_i = ~mclk_i;
   initial
   begin
      #3;
      forever #62.5 pci_i.clk = ~pci_i.clk;
   end
   // ==================================================
   // Design and far side
   // ==================================================
   ptdl_top u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .pci_i(pci_i),
      .top_of_memory_i(32'h0100_0000), .cpu_start_i(cpu_start_i), .cpu_i(cpu_i),
      .snoop_ack_i(snoop_ack_i), .snoop_retry_i(snoop_retry_i), .mem_ack_i(mem_ack_i),
      .address_retry_o(address_retry_o), .cpu_pass_o(cpu_pass_o),
      .pci_claim_o(pci_claim_o), .pci_retry_o(pci_retry_o), .snoop_req_o(snoop_req_o),
      .snoop_o(snoop_o), .mem_req_o(mem_req_o), .mem_write_o(mem_write_o),
      .mem_addr_o(mem_addr_o));
   ptdl_far u_far (.mclk_i(mclk_i), .snoop_req_i(snoop_req_o), .snoop_i(snoop_o),
      .mem_req_i(mem_req_o), .hit_i(hit), .delay_i(delay), .snoop_ack_o(snoop_ack_i),
      .snoop_retry_o(snoop_retry_i), .mem_ack_o(mem_ack_i));
   // Record what the block answers within a transaction
   always @(posedge mclk_i)
   begin
      if (pci_claim_o)
         saw_claim <= 1'b1;
      if (pci_retry_o)
         saw_retry <= 1'b1;
      if (mem_req_o)
         saw_addr <= mem_addr_o;
      if (mem_req_o)
         saw_wr <= mem_write_o;
   end
   // ==================================================
   // Shared tasks
   // ==================================================
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One PCI transaction: address phase, five data clocks, then idle
   task automatic acc(input logic [3:0] c, input logic [31:0] a, input logic [2:0] m,
      input logic ign, input logic lk, input logic [1:0] cr, input int ns, input int nm,
      input logic [35:0] sn, input logic [32:0] mw);
      int s0;
      int m0;
      s0 = u_far.snoops;
      m0 = u_far.mems;
      @(negedge pci_i.clk);
      @(posedge mclk_i);
      saw_claim <= 1'b0;
      saw_retry <= 1'b0;
      pci_i.frame_n <= 1'b0;
      pci_i.cmd <= c;
      pci_i.ad <= a;
      pci_i.master <= m;
      pci_i.ign_hi <= ign;
      @(negedge pci_i.clk);
      @(posedge mclk_i);
      pci_i.ad <= ~a;                // Data phase: bus no longer holds the address
      pci_i.cmd <= 4'h0;
      if (lk)
         pci_i.lock_n <= 1'b0;
      repeat (5) @(negedge pci_i.clk);
      @(posedge mclk_i);
      pci_i.frame_n <= 1'b1;
      repeat (3) @(negedge pci_i.clk);
      chk({34'h0, saw_claim, saw_retry}, {34'h0, cr});
      chk({35'h0, pci_claim_o}, 36'h0);
      chk(36'(u_far.snoops - s0), 36'(ns));
      chk(36'(u_far.mems - m0), 36'(nm));
      if (ns > 0)
         chk(u_far.last, sn);
      if (nm > 0)
         chk({3'h0, saw_wr, saw_addr}, {3'h0, mw});
   endtask : acc
   // One CPU cycle; answer judged 1 ns after the edge that takes it
   task automatic cpu_chk(input logic [3:0] t, input logic [31:0] a, input logic r);
      @(posedge mclk_i);
      cpu_start_i <= 1'b1;
      cpu_i <= {t, a};
      @(posedge mclk_i);
      cpu_start_i <= 1'b0;
      #1;
      chk({34'h0, address_retry_o, cpu_pass_o}, {34'h0, r, ~r});
   endtask : cpu_chk
   // ==================================================
   // Scenarios
   // ==================================================
   task automatic t_map;
      logic [3:0] rd[3] = '{4'h6, 4'hC, 4'hE};
      acc(4'h7, 32'h8000_0040, 3'h1, 1'b0, 1'b0, 2'b10, 1, 1,
         {4'h6, 32'h0000_0040}, {1'b1, 32'h0000_0040});
      acc(4'hF, 32'h80FF_FFE0, 3'h1, 1'b0, 1'b0, 2'b10, 1, 1,
         {4'h6, 32'h00FF_FFE0}, {1'b1, 32'h00FF_FFE0});
      foreach (rd[i])
         acc(rd[i], 32'h8000_0080, 3'h1, 1'b0, 1'b0, 2'b10, 1, 1,
            {4'hA, 32'h0000_0080}, {1'b0, 32'h0000_0080});
      acc(4'hE, 32'h0000_00C0, 3'h4, 1'b1, 1'b0, 2'b10, 1, 1,
         {4'hA, 32'h0000_00C0}, {1'b0, 32'h0000_00C0});
      $display("test t_map done");
   endtask : t_map
   task automatic t_refuse;
      logic [3:0] other[4] = '{4'h1, 4'h2, 4'h3, 4'hD};  // Legal non-memory commands
      foreach (other[i])
         acc(other[i], 32'h8000_0040, 3'h1, 1'b0, 1'b0, 2'b00, 0, 0, 0, 0);
      acc(4'h7, 32'h7FFF_FFE0, 3'h1, 1'b0, 1'b0, 2'b00, 0, 0, 0, 0);
      acc(4'h6, 32'h8100_0000, 3'h1, 1'b0, 1'b0, 2'b00, 0, 0, 0, 0);
      $display("test t_refuse done");
   endtask : t_refuse
   task automatic t_hit;
      hit <= 1'b1;
      delay <= 8'h14;
      acc(4'h7, 32'h8000_0040, 3'h1, 1'b0, 1'b0, 2'b11, 1, 0, {4'h6, 32'h0000_0040}, 0);
      hit <= 1'b0;
      delay <= 8'h02;
      $display("test t_hit done");
   endtask : t_hit
   task automatic t_lock;
      int s0;
      acc(4'h7, 32'h8000_0060, 3'h2, 1'b0, 1'b1, 2'b10, 2, 1,
         {4'h1, 32'h0000_0060}, {1'b1, 32'h0000_0060});
      cpu_chk(4'hD, 32'h0000_0064, 1'b1);
      cpu_chk(4'hD, 32'h0000_0080, 1'b0);
      cpu_chk(4'hF, 32'h0000_005C, 1'b0);
      cpu_chk(4'h9, 32'h0000_007C, 1'b1);
      cpu_chk(4'h2, 32'h0000_0060, 1'b1);
      acc(4'h7, 32'h8000_0100, 3'h3, 1'b0, 1'b1, 2'b10, 1, 1,
         {4'h6, 32'h0000_0100}, {1'b1, 32'h0000_0100});
      acc(4'h6, 32'h8000_0070, 3'h3, 1'b0, 1'b0, 2'b11, 0, 0, 0, 0);
      acc(4'h6, 32'h0000_0060, 3'h3, 1'b1, 1'b0, 2'b11, 0, 0, 0, 0);
      acc(4'h6, 32'h8000_0060, 3'h2, 1'b0, 1'b0, 2'b10, 1, 1,
         {4'hA, 32'h0000_0060}, {1'b0, 32'h0000_0060});
      s0 = u_far.snoops;
      @(negedge pci_i.clk);
      @(posedge mclk_i);
      pci_i.lock_n <= 1'b1;
      repeat (3) @(negedge pci_i.clk);
      chk(36'(u_far.snoops - s0), 36'h1);
      chk(u_far.last, {4'hA, 32'h0000_0060});
      cpu_chk(4'hD, 32'h0000_0064, 1'b0);
      $display("test t_lock done");
   endtask : t_lock
   // ==================================================
   // Verdict, watchdog and main sequence
   // ==================================================
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   initial
   begin
      #100000;
      fail_count++;
      test_done;
   end
   initial
   begin
      repeat (12) @(posedge mclk_i);
      chk({30'h0, address_retry_o, cpu_pass_o, pci_claim_o, pci_retry_o, snoop_req_o,
         mem_req_o}, 36'h0);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      t_map;
      t_refuse;
      t_hit;
      t_lock;
      test_done;
   end
endmodule : tb
